// ==== rtl/diar_pkg.sv ====
// package: constants, field layouts and types of the contact-input alarm and restart block
package diar_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int SEC_CYCLES = CLK_HZ;
	localparam int MIN_SECONDS = 60;
	localparam int NUM_INPUTS = 3;
	localparam int DLY_W = 16;
	localparam int CNT_W = 8;
	localparam int SEC_W = 27;
	localparam int MIN_W = 6;
	// register map, byte addresses on the plain port
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_GLOBAL = 8'h0c;
	localparam logic [7:0] ADDR_MODULES = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;
	localparam logic [7:0] ADDR_CFG0 = 8'h20;
	localparam logic [7:0] ADDR_DLY0 = 8'h24;
	localparam logic [7:0] ADDR_RST0 = 8'h28;
	localparam logic [7:0] INPUT_STRIDE = 8'h10;
	// per-input config word fields
	localparam int F_POL = 0;
	localparam int F_AEN = 1;
	localparam int F_LKO = 2;
	localparam int F_LOC = 3;
	// ctrl fields
	localparam int F_RUN_CMD = 0;
	localparam int F_HOA = 1;
	localparam int F_VSC = 2;
	localparam int F_CLR_LOCK = 3;
	// interrupt event bits
	localparam int EV_ALARM = 0;
	localparam int EV_SHUTDOWN = 1;
	localparam int EV_RESTART = 2;
	localparam int EV_LOCKOUT = 3;
	localparam int EV_START_BTN = 4;
	localparam int EV_W = 5;
	// module table bits
	localparam int M_SYS = 0;
	localparam int M_PCM = 1;
	localparam int M_SENSOR = 2;
	localparam int M_EXPANSION_IO_MODULE_ONE = 3;
	localparam int M_W = 6;
	// reset values
	localparam logic RST_POL = 1'b1;
	localparam logic RST_AEN = 1'b0;
	localparam logic RST_LKO = 1'b0;
	localparam logic RST_LOC = 1'b1;
	localparam logic [DLY_W-1:0] RST_BYP = 16'h0000;
	localparam logic [DLY_W-1:0] RST_SD = 16'h0001;
	localparam logic [CNT_W-1:0] RST_STARTS = 8'h03;
	localparam logic [DLY_W-1:0] RST_RDLY = 16'h001e;

	typedef enum logic [3:0] {
		DIAR_IDLE = 4'b0001,
		DIAR_RUN = 4'b0010,
		DIAR_WAIT = 4'b0100,
		DIAR_LOCK = 4'b1000
	} diar_mode_t;

	typedef struct packed {
		logic pol;
		logic aen;
		logic lko;
		logic loc;
		logic [DLY_W-1:0] byp;
		logic [DLY_W-1:0] sd;
		logic [CNT_W-1:0] starts;
		logic [DLY_W-1:0] rdly;
	} diar_incfg_t;

	typedef struct packed {
		logic [CNT_W-1:0] starts;
		logic [DLY_W-1:0] rdly;
	} diar_glob_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} diar_bus_t;
endpackage

// ==== rtl/diar_tick.sv ====
// timebase: one-second and one-minute enable pulses from the system clock
`timescale 1ns/10ps
module diar_tick #(
	parameter int SEC_COUNT = diar_pkg::SEC_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	output logic sec_tick,
	output logic min_tick
);
	typedef struct packed {
		logic [diar_pkg::SEC_W-1:0] cyc;
		logic [diar_pkg::MIN_W-1:0] secs;
		logic sec;
		logic min;
	} diar_tick_st_t;
	diar_tick_st_t s_q, s_d;

	// divider chain, minute fires in the same cycle as the sixtieth second
	always_comb begin
		s_d = s_q;
		s_d.sec = 1'b0;
		s_d.min = 1'b0;
		if (s_q.cyc == diar_pkg::SEC_W'(SEC_COUNT - 1)) begin
			s_d.cyc = '0;
			s_d.sec = 1'b1;
			if (s_q.secs == diar_pkg::MIN_W'(diar_pkg::MIN_SECONDS - 1)) begin
				s_d.secs = '0;
				s_d.min = 1'b1;
			end else begin
				s_d.secs = s_q.secs + 1'b1;
			end
		end else begin
			s_d.cyc = s_q.cyc + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sec_tick = s_q.sec;
	assign min_tick = s_q.min;

	chk_min_on_sec: assert property (@(posedge clock) disable iff (!nrst)
		s_q.min |-> s_q.sec) else $error("minute tick without second tick");
endmodule // diar_tick

// ==== rtl/diar_top.sv ====
// contact-input alarm qualification, lockout and auto-restart with module enable table
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module diar_top #(
	parameter int SEC_COUNT = diar_pkg::SEC_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] contact_in,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] module_req,
	output logic [31:0] reg_rdata,
	output logic motor_run,
	output logic [5:0] module_grant,
	output logic [1:0] hoa_ctrl,
	output logic irq
);
	localparam int N = diar_pkg::NUM_INPUTS;
	localparam int DW = diar_pkg::DLY_W;
	localparam int CW = diar_pkg::CNT_W;

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] status;
		diar_pkg::diar_incfg_t [N-1:0] cfg;
		diar_pkg::diar_glob_t glob;
		logic run_cmd;
		logic hand_off_auto_select;
		logic vsc;
		logic [diar_pkg::M_W-1:0] mod_en;
		logic [diar_pkg::EV_W-1:0] ev_st;
		logic [diar_pkg::EV_W-1:0] ev_mask;
		diar_pkg::diar_mode_t mode;
		logic [N-1:0][DW-1:0] byp_cnt;
		logic [DW-1:0] sd_cnt;
		logic [DW:0] wait_cnt;
		logic [CW-1:0] restarts;
		logic [1:0] cause;
		logic [N-1:0] btn_prev;
		logic [31:0] rdata;
		logic run;
		logic [5:0] grant;
		logic [1:0] hoa_out;
		logic irq;
	} diar_st_t;
	diar_st_t s_q, s_d;

	logic sec_tick;
	logic min_tick;

	diar_tick #(
		.SEC_COUNT(SEC_COUNT)
	) u_tick (
		.clock(clock),
		.nrst(nrst),
		.sec_tick(sec_tick),
		.min_tick(min_tick)
	);

	// byte address of a per-input register: base plus input index times stride
	function automatic logic [7:0] in_addr(input logic [7:0] base, input int idx);
		in_addr = base + 8'(idx * int'(diar_pkg::INPUT_STRIDE));
	endfunction

	// downcount that saturates at zero on a tick
	function automatic logic [DW-1:0] dec_sat(input logic [DW-1:0] v, input logic tk);
		dec_sat = (tk && v != '0) ? v - 1'b1 : v;
	endfunction

	// tick counter load: one extra tick, since the free divider may fire at once
	function automatic logic [DW-1:0] arm_cnt(input logic [DW-1:0] v);
		arm_cnt = (v == '0) ? '0 : ((&v[DW-1:1]) ? {{(DW-1){1'b1}}, 1'b0} : v + 1'b1);
	endfunction

	logic [N-1:0] match;
	logic [N-1:0] usable;
	logic [N-1:0] qual;
	logic [N-1:0] armed;
	logic any_armed;
	logic [1:0] first_idx;
	logic any_qual;
	logic [CW-1:0] lim_starts;
	logic [DW-1:0] lim_dly;
	logic [diar_pkg::EV_W-1:0] ev_set;
	diar_pkg::diar_incfg_t cw;

	// alarm qualification per input; hoa takes its inputs off alarm duty
	always_comb begin
		usable = s_q.hand_off_auto_select ? 3'b000 : 3'b111;
		match = '0;
		qual = '0;
		armed = '0;
		for (int i = 0; i < N; i++) begin
			match[i] = (s_q.status[i] == s_q.cfg[i].pol);
			qual[i] = match[i] && s_q.cfg[i].aen && usable[i];
			armed[i] = qual[i] && (s_q.byp_cnt[i] == '0); // own bypass spent
		end
		any_qual = |qual;
		any_armed = |armed;
		first_idx = armed[0] ? 2'd0 : (armed[1] ? 2'd1 : 2'd2);
	end

	// restart source: cause input's own figures or the global ones
	always_comb begin
		if (s_q.cfg[s_q.cause].loc) begin
			lim_starts = s_q.cfg[s_q.cause].starts;
			lim_dly = s_q.cfg[s_q.cause].rdly;
		end else begin
			lim_starts = s_q.glob.starts;
			lim_dly = s_q.glob.rdly;
		end
	end

	// one combinational pass fills the next state
	always_comb begin
		s_d = s_q;
		ev_set = '0;
		cw = '0;
		// contact pins: three flops, accept when last two agree;
		// open terminal pulls high, so the pin level is the status
		s_d.s1 = contact_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < N; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.status[i] = s_q.s3[i];
			end
		end
		// start button on input one, press is a closure
		s_d.btn_prev = s_q.status;
		if (s_q.hand_off_auto_select && s_q.btn_prev[0] && !s_q.status[0]) begin
			ev_set[diar_pkg::EV_START_BTN] = 1'b1;
		end
		s_d.hoa_out = s_q.hand_off_auto_select ? s_q.status[2:1] : 2'b00;

		// motor sequencer
		case (s_q.mode)
			diar_pkg::DIAR_IDLE: begin
				if (s_q.run_cmd || ev_set[diar_pkg::EV_START_BTN]) begin
					s_d.mode = diar_pkg::DIAR_RUN;
					for (int i = 0; i < N; i++) begin
						s_d.byp_cnt[i] = arm_cnt(s_q.cfg[i].byp);
					end
					s_d.sd_cnt = '1;
					s_d.restarts = '0;
				end
			end
			diar_pkg::DIAR_RUN: begin
				for (int i = 0; i < N; i++) begin
					s_d.byp_cnt[i] = dec_sat(s_q.byp_cnt[i], sec_tick);
				end
				if (!s_q.run_cmd && !s_q.hand_off_auto_select) begin
					s_d.mode = diar_pkg::DIAR_IDLE;
				end else if (any_armed) begin
					// shutdown window opens only once bypass is spent
					if (s_q.sd_cnt == '1) begin
						s_d.sd_cnt = arm_cnt(s_q.cfg[first_idx].sd);
					end else if (s_q.sd_cnt == '0) begin
						s_d.mode = diar_pkg::DIAR_WAIT;
						s_d.cause = first_idx;
						ev_set[diar_pkg::EV_SHUTDOWN] = 1'b1;
						if (s_q.cfg[first_idx].lko) begin
							s_d.mode = diar_pkg::DIAR_LOCK;
							ev_set[diar_pkg::EV_LOCKOUT] = 1'b1;
						end
					end else begin
						s_d.sd_cnt = dec_sat(s_q.sd_cnt, sec_tick);
					end
				end else begin
					s_d.sd_cnt = '1; // alarm gone, delay rearms
				end
				if (s_d.mode == diar_pkg::DIAR_WAIT) begin
					s_d.wait_cnt = '0;
				end
			end
			diar_pkg::DIAR_WAIT: begin
				// minute divider runs free: one extra tick keeps at least the full delay
				if (!s_q.run_cmd && !s_q.hand_off_auto_select) begin
					s_d.mode = diar_pkg::DIAR_IDLE;
				end else if (s_q.restarts >= lim_starts) begin
					s_d.mode = diar_pkg::DIAR_LOCK;
					ev_set[diar_pkg::EV_LOCKOUT] = 1'b1;
				end else if (lim_dly == '0 || s_q.wait_cnt > {1'b0, lim_dly}) begin
					s_d.mode = diar_pkg::DIAR_RUN;
					s_d.restarts = s_q.restarts + 1'b1;
					for (int i = 0; i < N; i++) begin
						s_d.byp_cnt[i] = arm_cnt(s_q.cfg[i].byp);
					end
					s_d.sd_cnt = '1;
					ev_set[diar_pkg::EV_RESTART] = 1'b1;
				end else if (min_tick) begin
					s_d.wait_cnt = s_q.wait_cnt + 1'b1;
				end
			end
			diar_pkg::DIAR_LOCK: begin
				// only software leaves lockout, never a timer
				if (s_q.run_cmd == 1'b0) begin
					s_d.mode = diar_pkg::DIAR_IDLE;
				end
			end
			default: begin
				s_d.mode = diar_pkg::DIAR_IDLE;
			end
		endcase
		s_d.run = (s_d.mode == diar_pkg::DIAR_RUN);
		if (any_qual) begin
			ev_set[diar_pkg::EV_ALARM] = 1'b1;
		end

		// module table: system always on, power module follows speed mode
		s_d.mod_en[diar_pkg::M_SYS] = 1'b1;
		s_d.mod_en[diar_pkg::M_PCM] = s_q.vsc;
		s_d.grant = module_req & s_q.mod_en;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				diar_pkg::ADDR_STATUS: s_d.ev_st = s_q.ev_st & ~reg_wdata[diar_pkg::EV_W-1:0];
				diar_pkg::ADDR_MASK: s_d.ev_mask = reg_wdata[diar_pkg::EV_W-1:0];
				diar_pkg::ADDR_CTRL: begin
					s_d.run_cmd = reg_wdata[diar_pkg::F_RUN_CMD];
					s_d.hand_off_auto_select = reg_wdata[diar_pkg::F_HOA];
					s_d.vsc = reg_wdata[diar_pkg::F_VSC];
				end
				diar_pkg::ADDR_GLOBAL: begin
					s_d.glob.starts = reg_wdata[CW+DW-1:DW];
					s_d.glob.rdly = reg_wdata[DW-1:0];
				end
				diar_pkg::ADDR_MODULES: begin
					// sensor and three expansion slots are software switched
					s_d.mod_en[diar_pkg::M_W-1:diar_pkg::M_SENSOR] =
						reg_wdata[diar_pkg::M_W-1:diar_pkg::M_SENSOR];
				end
				default: begin
				end
			endcase
			for (int i = 0; i < N; i++) begin
				cw = s_q.cfg[i];
				if (reg_addr == in_addr(diar_pkg::ADDR_CFG0, i)) begin
					cw.pol = reg_wdata[diar_pkg::F_POL];
					cw.aen = reg_wdata[diar_pkg::F_AEN];
					cw.lko = reg_wdata[diar_pkg::F_LKO];
					cw.loc = reg_wdata[diar_pkg::F_LOC];
				end
				if (reg_addr == in_addr(diar_pkg::ADDR_DLY0, i)) begin
					cw.sd = reg_wdata[2*DW-1:DW];
					cw.byp = reg_wdata[DW-1:0];
				end
				if (reg_addr == in_addr(diar_pkg::ADDR_RST0, i)) begin
					cw.starts = reg_wdata[CW+DW-1:DW];
					cw.rdly = reg_wdata[DW-1:0];
				end
				s_d.cfg[i] = cw;
			end
		end
		// new events win over a clear in the same cycle
		s_d.ev_st = s_d.ev_st | ev_set;
		s_d.irq = |(s_d.ev_st & s_d.ev_mask);

		// register reads, data valid the next cycle
		s_d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				diar_pkg::ADDR_STATUS: s_d.rdata = 32'(s_q.ev_st);
				diar_pkg::ADDR_MASK: s_d.rdata = 32'(s_q.ev_mask);
				diar_pkg::ADDR_CTRL: s_d.rdata = {29'h0, s_q.vsc, s_q.hand_off_auto_select, s_q.run_cmd};
				diar_pkg::ADDR_GLOBAL: s_d.rdata = {8'h00, s_q.glob.starts, s_q.glob.rdly};
				diar_pkg::ADDR_MODULES: s_d.rdata = 32'(s_q.mod_en);
				diar_pkg::ADDR_STATE: s_d.rdata = {s_q.restarts, 10'h000, s_q.cause,
					s_q.mode, 5'h00, s_q.status};
				default: begin
				end
			endcase
			for (int i = 0; i < N; i++) begin
				if (reg_addr == in_addr(diar_pkg::ADDR_CFG0, i)) begin
					s_d.rdata = {28'h0, s_q.cfg[i].loc, s_q.cfg[i].lko,
						s_q.cfg[i].aen, s_q.cfg[i].pol};
				end
				if (reg_addr == in_addr(diar_pkg::ADDR_DLY0, i)) begin
					s_d.rdata = {s_q.cfg[i].sd, s_q.cfg[i].byp};
				end
				if (reg_addr == in_addr(diar_pkg::ADDR_RST0, i)) begin
					s_d.rdata = {8'h00, s_q.cfg[i].starts, s_q.cfg[i].rdly};
				end
			end
		end
	end

	// state register; defaults follow the factory settings
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.s1 <= '1;
			s_q.s2 <= '1;
			s_q.s3 <= '1;
			s_q.status <= '1;
			s_q.btn_prev <= '1;
			s_q.mode <= diar_pkg::DIAR_IDLE;
			s_q.mod_en <= 6'h01;
			s_q.sd_cnt <= '1;
			s_q.glob <= {diar_pkg::RST_STARTS, diar_pkg::RST_RDLY};
			for (int i = 0; i < N; i++) begin
				s_q.cfg[i] <= {diar_pkg::RST_POL, diar_pkg::RST_AEN, diar_pkg::RST_LKO,
					diar_pkg::RST_LOC, diar_pkg::RST_BYP, diar_pkg::RST_SD,
					diar_pkg::RST_STARTS, diar_pkg::RST_RDLY};
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign motor_run = s_q.run;
	assign module_grant = s_q.grant;
	assign hoa_ctrl = s_q.hoa_out;
	assign irq = s_q.irq;

	chk_sys_enabled: assert property (@(posedge clock) disable iff (!nrst)
		##1 s_q.mod_en[diar_pkg::M_SYS]) else $error("system controller not enabled");
	chk_pcm_follow: assert property (@(posedge clock) disable iff (!nrst)
		##1 (s_q.mod_en[diar_pkg::M_PCM] == $past(s_q.vsc)))
		else $error("power module enable wrong");
	chk_grant_gated: assert property (@(posedge clock) disable iff (!nrst)
		|(module_grant & ~$past(s_q.mod_en)) == 1'b0) else $error("grant to disabled module");
	chk_lock_hold: assert property (@(posedge clock) disable iff (!nrst)
		(s_q.mode == diar_pkg::DIAR_LOCK && s_q.run_cmd) |=> !motor_run)
		else $error("restart out of lockout");
	chk_hoa_no_alarm: assert property (@(posedge clock) disable iff (!nrst)
		s_q.hand_off_auto_select |-> qual == 3'b000) else $error("alarm from hand-off-auto input");
	chk_hoa_pins: assert property (@(posedge clock) disable iff (!nrst)
		s_q.hand_off_auto_select |=> hoa_ctrl == $past(s_q.status[2:1])) else $error("hoa inputs not passed");
	chk_alarm_gated: assert property (@(posedge clock) disable iff (!nrst)
		(s_q.mode == diar_pkg::DIAR_RUN && s_d.mode == diar_pkg::DIAR_WAIT) |-> any_qual)
		else $error("shutdown without enabled alarm");
	chk_bypass_first: assert property (@(posedge clock) disable iff (!nrst)
		(s_q.mode == diar_pkg::DIAR_RUN && (qual & {s_q.byp_cnt[2] == '0, s_q.byp_cnt[1] == '0,
		s_q.byp_cnt[0] == '0}) == 3'b000) |=> s_q.mode != diar_pkg::DIAR_WAIT)
		else $error("shutdown during bypass");
	chk_restart_limit: assert property (@(posedge clock) disable iff (!nrst)
		ev_set[diar_pkg::EV_RESTART] |-> s_q.restarts < lim_starts)
		else $error("restart over limit");
endmodule // diar_top

// ==== verif/diar_contact_model.sv ====
// model of the three dry-contact switches wired to the terminals
`timescale 1ns/10ps
module diar_contact_model (
	input wire logic [2:0] close_cmd,
	output logic [2:0] contact_in
);
	// open contact floats up to one through the pull-up, closed shorts to common
	assign contact_in = ~close_cmd;
endmodule // diar_contact_model

// ==== verif/testbench.sv ====
// self-checking bench of the contact-input alarm and restart block
`timescale 1ns/10ps
module testbench;
	typedef struct {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} diar_row_t;
	logic clock;
	logic nrst;
	logic [2:0] sw_close;
	logic [2:0] contact_in;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [5:0] module_req;
	logic [31:0] reg_rdata;
	logic motor_run;
	logic [5:0] module_grant;
	logic [1:0] hoa_ctrl;
	logic irq;
	logic [31:0] d;
	int err_total;
	int check_count;
	diar_row_t rows [6];

	// ten cycles per second keeps a one-minute restart wait at 600 cycles
	diar_top #(.SEC_COUNT(10)) u_diar_top (
		.clock(clock),
		.nrst(nrst),
		.contact_in(contact_in),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.module_req(module_req),
		.reg_rdata(reg_rdata),
		.motor_run(motor_run),
		.module_grant(module_grant),
		.hoa_ctrl(hoa_ctrl),
		.irq(irq)
	);

	diar_contact_model u_diar_contact_model (
		.close_cmd(sw_close),
		.contact_in(contact_in)
	);

	// free-running system clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// bounded wait for the motor output to reach a level
	task automatic wait_run(input logic v, input int lim);
		int n;
		n = 0;
		while (motor_run !== v && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({31'h0, motor_run}, {31'h0, v});
	endtask

	// motor output must keep its level for n cycles
	task automatic hold(input logic v, input int n);
		logic ok;
		ok = 1'b1;
		repeat (n) begin
			@(posedge clock);
			#1;
			if (motor_run !== v)
				ok = 1'b0;
		end
		chk({31'h0, ok}, 32'h1);
	endtask

	// start, expect a delayed trip, then the lock mode; config cleared afterwards
	task automatic trip(input logic [7:0] base, input logic [31:0] cfg, input logic [31:0] dly,
			input int n);
		wr(base, cfg);
		wr(base + 8'h04, dly);
		wr(diar_pkg::ADDR_CTRL, 32'h1);
		wait_run(1'b1, 10);
		hold(1'b1, n);
		wait_run(1'b0, 60);
		rd(diar_pkg::ADDR_STATE, d);
		chk({28'h0, d[11:8]}, 32'h8);
		wr(diar_pkg::ADDR_CTRL, 32'h0);
		wr(base, 32'h0);
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog sized well past the few thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		sw_close = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		module_req = 6'h3f;
		err_total = 0;
		check_count = 0;
		rows[0] = '{8'h04, 32'h1f, 32'h1f};
		rows[1] = '{8'h0c, 32'h00020005, 32'h00020005};
		rows[2] = '{8'h24, 32'h00040002, 32'h00040002};
		rows[3] = '{8'h38, 32'h00050007, 32'h00050007};
		rows[4] = '{8'h3c, 32'h00001234, 32'h0};
		rows[5] = '{8'h10, 32'h3c, 32'h3d};
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			chk(d, rows[i].exp);
		end
		chk({26'h0, module_grant}, 32'h3d);
		wr(diar_pkg::ADDR_CTRL, 32'h4);
		rd(diar_pkg::ADDR_MODULES, d);
		chk(d, 32'h3f);
		// second reset in mid-run restores every default
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rd(diar_pkg::ADDR_CFG0, d);
		chk(d, 32'h9);
		rd(diar_pkg::ADDR_DLY0, d);
		chk(d, 32'h00010000);
		rd(diar_pkg::ADDR_RST0, d);
		chk(d, 32'h0003001e);
		rd(diar_pkg::ADDR_MODULES, d);
		chk(d, 32'h1);
		rd(diar_pkg::ADDR_STATE, d);
		chk(d, 32'h00000107);
		// one local restart after one minute, then the limit locks
		wr(diar_pkg::ADDR_RST0, 32'h00010001);
		wr(diar_pkg::ADDR_MASK, 32'h2);
		wr(diar_pkg::ADDR_CTRL, 32'h1);
		wait_run(1'b1, 10);
		hold(1'b1, 40);
		wr(diar_pkg::ADDR_CFG0, 32'ha);
		hold(1'b1, 40);
		sw_close <= 3'h1;
		hold(1'b1, 8);
		wait_run(1'b0, 40);
		chk({31'h0, irq}, 32'h1);
		rd(diar_pkg::ADDR_STATE, d);
		chk({29'h0, d[2:0]}, 32'h6);
		wr(diar_pkg::ADDR_STATUS, 32'h2);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, irq}, 32'h0);
		hold(1'b0, 590);
		wait_run(1'b1, 700);
		wait_run(1'b0, 60);
		rd(diar_pkg::ADDR_STATE, d);
		chk(d & 32'hff000f00, 32'h01000800);
		rd(diar_pkg::ADDR_STATUS, d);
		chk(d, 32'hf);
		wr(diar_pkg::ADDR_CTRL, 32'h0);
		wr(diar_pkg::ADDR_CFG0, 32'h0);
		sw_close <= 3'h0;
		trip(8'h20, 32'h7, 32'h00010003, 25);
		wr(diar_pkg::ADDR_GLOBAL, 32'h00000001);
		trip(8'h30, 32'h3, 32'h00010000, 5);
		trip(8'h40, 32'h7, 32'h00010000, 5);
		// hand-off-auto: input one starts, inputs two and three never trip
		wr(8'h40, 32'h3);
		wr(diar_pkg::ADDR_CTRL, 32'h2);
		sw_close <= 3'h2;
		repeat (8) @(posedge clock);
		#1;
		chk({30'h0, hoa_ctrl}, 32'h2);
		sw_close <= 3'h3;
		wait_run(1'b1, 12);
		hold(1'b1, 40);
		print_verdict();
	end
endmodule // testbench
